// ===== inc/strap_regmap_consts.vh
// register offsets, reset values and strap encodings of the configuration block
`ifndef STRAP_REGMAP_CONSTS_VH
`define STRAP_REGMAP_CONSTS_VH
`define OFS_NET_CONTROL     8'h00
`define OFS_NET_STATUS      8'h01
`define OFS_TX_CONTROL      8'h02
`define OFS_RX_CONTROL      8'h05
`define OFS_RX_STATUS       8'h06
`define OFS_RX_OVF_COUNT    8'h07
`define OFS_BP_THRESH       8'h08
`define OFS_FLOW_THRESH     8'h09
`define OFS_FLOW_CONTROL    8'h0a
`define OFS_EP_CONTROL      8'h0b
`define OFS_EP_ADDRESS      8'h0c
`define OFS_EP_DATA_LO      8'h0d
`define OFS_EP_DATA_HI      8'h0e
`define OFS_WAKEUP_CONTROL  8'h0f
`define OFS_STATION_FIRST   8'h10
`define OFS_STATION_LAST    8'h15
`define OFS_MCAST_FIRST     8'h16
`define OFS_MCAST_LAST      8'h1d
`define OFS_GP_CONTROL      8'h1e
`define OFS_GP_DATA         8'h1f
`define OFS_MAKER_LO        8'h28
`define OFS_MAKER_HI        8'h29
`define OFS_PART_LO         8'h2a
`define OFS_PART_HI         8'h2b
`define OFS_REVISION        8'h2c
`define OFS_TX_SPECIAL      8'h2d
`define OFS_EXT_PHY_FORCE   8'h2e
`define OFS_TX_CSUM         8'h31
`define OFS_RX_CSUM         8'h32
`define OFS_EXT_PHY_ADDR    8'h33
`define OFS_PORT2_CONTROL   8'h34
`define OFS_PORT2_DATA      8'h35
`define OFS_PORT3_CONTROL   8'h36
`define OFS_PORT3_DATA      8'h37
`define OFS_EP_CONTROL2     8'h3a
`define OFS_PAUSE_CSR       8'h3d
`define OFS_CNT_FIRST       8'h81
`define OFS_CNT_LAST        8'h86
`define OFS_MODE_CONTROL    8'h91
`define OFS_SQUELCH         8'h95
`define OFS_USB_ADDR_A      8'h96
`define OFS_USB_DEV_ADDR    8'hf0
`define OFS_RX_TALLY        8'hf1
`define OFS_TX_TALLY        8'hf2
`define OFS_USB_CONTROL     8'hf4
`define RST_ZERO            8'h00
`define RST_BP_THRESH       8'h37
`define RST_FLOW_THRESH     8'h38
`define RST_EP_ADDRESS      8'h40
`define RST_GP_CONTROL      8'h01
`define RST_EXT_PHY_ADDR    8'h01
`define RST_PAUSE_CSR       8'h04
`define RST_SQUELCH         8'h04
`define RST_TX_TALLY        8'h10
`define RST_MCAST_LAST      8'h80
`define PHY_IF_MII          2'b00
`define PHY_IF_REV_MII      2'b01
`define PHY_IF_RMII         2'b10
`define PHY_IF_RESERVED     2'b11
`define NCR_SW_RESET_BIT    0
`define NCR_CLEAR_MODE_BIT  5
`define SW_RESET_TIME_NS    10000
`define CLK_PERIOD_NS       8
`define SW_RESET_CYCLES     (`SW_RESET_TIME_NS / `CLK_PERIOD_NS)
`endif

// ===== sim/strap_regmap_properties.sv
// concurrent checks on the configuration block ports
`timescale 1ns/100ps
module strap_regmap_props #(
  parameter [15:0] MAKER_CODE    = 16'h1234,
  parameter [7:0]  REVISION_CODE = 8'h0a
) (
  input wire       clk_sys, sys_rst, cmd_wr, cmd_rd, cmd_rvalid_ff,
  input wire       gpio_mode_ff, sw_reset_active_ff,
  input wire [1:0] phy_if_mode_ff,
  input wire [7:0] cmd_offset, cmd_wdata, cmd_rdata_ff, port2_oe_n_ff, port3_oe_n_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  rd_answer_a: assert property (cmd_rd |=> cmd_rvalid_ff)
    else $error("read not answered");
  no_stray_a: assert property (!cmd_rd |=> !cmd_rvalid_ff)
    else $error("stray read answer");
  strap_hold_a: assert property ((!$past(sys_rst) && !$past(sys_rst, 2))
    |-> $stable(phy_if_mode_ff) && $stable(gpio_mode_ff))
    else $error("latched strap moved");
  port2_dir_a: assert property (cmd_wr && cmd_offset == 8'h34 && gpio_mode_ff
    && !sw_reset_active_ff |=> ##2 port2_oe_n_ff == ~$past(cmd_wdata, 3))
    else $error("port 2 direction wrong");
  port3_dir_a: assert property (cmd_wr && cmd_offset == 8'h36 && gpio_mode_ff
    && !sw_reset_active_ff |=> ##2 port3_oe_n_ff == ~$past(cmd_wdata, 3))
    else $error("port 3 direction wrong");
  sw_start_a: assert property (cmd_wr && cmd_offset == 8'h00 && cmd_wdata[0]
    && !sw_reset_active_ff |=> sw_reset_active_ff)
    else $error("software reset not started");
  sw_span_a: assert property ($rose(sw_reset_active_ff)
    |-> sw_reset_active_ff[*4] ##1 !sw_reset_active_ff)
    else $error("software reset span wrong");
  sw_default_a: assert property (cmd_rd && cmd_offset == 8'h08 && sw_reset_active_ff
    |=> cmd_rdata_ff == 8'h37)
    else $error("threshold not at default");
  rev_fixed_a: assert property (cmd_rd && cmd_offset == 8'h2c
    |=> cmd_rdata_ff == REVISION_CODE)
    else $error("revision code wrong");
  maker_fixed_a: assert property (cmd_rd && cmd_offset == 8'h28
    |=> cmd_rdata_ff == MAKER_CODE[7:0])
    else $error("maker code wrong");
  sw_seen_c: cover property ($rose(sw_reset_active_ff));
  rev_read_c: cover property (cmd_rd && cmd_offset == 8'h2c);
  port2_wr_c: cover property (cmd_wr && cmd_offset == 8'h34 && gpio_mode_ff);
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the strap and register block
`timescale 1ns/100ps
module tb_top;
  // {offset, default} pairs read straight after reset
  localparam [255:0] ROWS = {128'h0837_0938_0c40_1e01_3301_3d04_9504_f210,
                             128'h3400_3500_3600_3700_8100_8600_0000_1d80};
  reg        clk_sys, sys_rst, load_v;
  reg  [5:0] straps, stat_event;
  reg  [2:0] load_i;
  reg  [7:0] load_b, port2_in, port3_in, rd_val;
  wire       cmd_wr, cmd_rd, cmd_rvalid_ff, force_small, hdr_four, xtal, gpio_mode, sw_act;
  wire [1:0] phy_mode;
  wire [7:0] cmd_offset, cmd_wdata, cmd_rdata_ff, p2_out, p2_oe_n, p3_out, p3_oe_n;
  integer    failures, n_checks, i, k;
  vendor_host u_host (.clk_sys(clk_sys), .cmd_rdata_ff(cmd_rdata_ff),
    .cmd_rvalid_ff(cmd_rvalid_ff), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_offset(cmd_offset), .cmd_wdata(cmd_wdata));
  // identity values arbitrary; short software reset keeps the run brief
  strap_regmap #(.MAKER_CODE(16'hbeef), .PART_CODE(16'h7e57), .REVISION_CODE(8'h3c),
    .SW_RESET_CYC(4)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .phy_if_strap_hi(straps[5]), .phy_if_strap_lo(straps[4]), .eeprom_type_strap(straps[3]),
    .rx_header_format_strap(straps[2]), .clock_source_strap(straps[1]),
    .test_mode_one_pin(straps[0]), .phy_if_mode_ff(phy_mode),
    .eeprom_force_small_ff(force_small), .rx_header_four_ff(hdr_four),
    .clk_from_crystal_ff(xtal), .gpio_mode_ff(gpio_mode), .sw_reset_active_ff(sw_act),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_offset(cmd_offset), .cmd_wdata(cmd_wdata),
    .cmd_rdata_ff(cmd_rdata_ff), .cmd_rvalid_ff(cmd_rvalid_ff), .eeprom_load_valid(load_v),
    .eeprom_load_index(load_i), .eeprom_load_byte(load_b), .stat_event(stat_event),
    .port2_in(port2_in), .port2_out_ff(p2_out), .port2_oe_n_ff(p2_oe_n),
    .port3_in(port3_in), .port3_out_ff(p3_out), .port3_oe_n_ff(p3_oe_n));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
      end
    end
  endtask
  task rchk(input [7:0] o, input [7:0] e);
    begin
      u_host.rd(o, rd_val);
      chk(rd_val, e);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // ****************************
  // main sequence
  // ****************************
  initial begin
    {sys_rst, load_v, load_i, load_b, stat_event} = {1'b1, 18'h0_0000};
    {straps, port2_in, port3_in} = {6'h00, 8'h00, 8'h00};
    failures = 0;
    n_checks = 0;
    for (k = 0; k < 2; k = k + 1) begin
      @(posedge clk_sys);
      straps <= k ? 6'b101011 : 6'b010100;
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk({2'b00, phy_mode, force_small, hdr_four, xtal, gpio_mode}, {2'b00, straps});
      straps <= ~straps;
      repeat (5) @(posedge clk_sys);
      chk({2'b00, phy_mode, force_small, hdr_four, xtal, gpio_mode}, {2'b00, ~straps});
    end
    for (i = 0; i < 16; i = i + 1)
      rchk(ROWS[255-16*i -: 8], ROWS[247-16*i -: 8]);
    u_host.wr(8'h34, 8'hff);
    u_host.wr(8'h35, 8'ha5);
    rchk(8'h35, 8'ha5);
    chk(p2_out, 8'ha5);
    chk(p2_oe_n, 8'h00);
    // input half of port 3 reads the pins, so drive them only from here on
    port3_in <= 8'ha0;
    u_host.wr(8'h36, 8'h0f);
    u_host.wr(8'h37, 8'hff);
    rchk(8'h37, 8'haf);
    chk(p3_oe_n, 8'hf0);
    chk(p3_out, 8'hff);
    u_host.wr(8'h2c, 8'h55);
    u_host.wr(8'h06, 8'hff);
    rchk(8'h2c, 8'h3c);
    rchk(8'h2b, 8'h7e);
    rchk(8'h28, 8'hef);
    rchk(8'h06, 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge clk_sys);
      {load_v, load_i, load_b} <= {1'b1, i[2:0], 8'hc0 + i[7:0]};
      @(posedge clk_sys);
      load_v <= 1'b0;
    end
    repeat (3) begin
      @(posedge clk_sys);
      stat_event <= 6'h3f;
      @(posedge clk_sys);
      stat_event <= 6'h00;
    end
    for (i = 0; i < 6; i = i + 1) begin
      rchk(8'h10 + i[7:0], 8'hc0 + i[7:0]);
      rchk(8'h81 + i[7:0], 8'h03);
      rchk(8'h81 + i[7:0], 8'h00);
    end
    u_host.wr(8'h08, 8'h5a);
    rchk(8'h08, 8'h5a);
    u_host.wr(8'h00, 8'h01);
    rchk(8'h08, 8'h37);
    repeat (6) @(posedge clk_sys);
    rchk(8'h35, 8'h00);
    rchk(8'h10, 8'hc0);
    complete_run;
  end
  initial begin
    #100000;
    failures = failures + 1;
    complete_run;
  end
endmodule
bind strap_regmap strap_regmap_props #(.MAKER_CODE(MAKER_CODE),
  .REVISION_CODE(REVISION_CODE)) u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rvalid_ff(cmd_rvalid_ff),
  .gpio_mode_ff(gpio_mode_ff), .sw_reset_active_ff(sw_reset_active_ff),
  .phy_if_mode_ff(phy_if_mode_ff), .cmd_offset(cmd_offset), .cmd_wdata(cmd_wdata),
  .cmd_rdata_ff(cmd_rdata_ff), .port2_oe_n_ff(port2_oe_n_ff),
  .port3_oe_n_ff(port3_oe_n_ff));

// ===== sim/vendor_host.sv
// host side model issuing vendor register commands
`timescale 1ns/100ps
module vendor_host (
  input  wire       clk_sys,
  input  wire [7:0] cmd_rdata_ff,
  input  wire       cmd_rvalid_ff,
  output reg        cmd_wr,
  output reg        cmd_rd,
  output reg  [7:0] cmd_offset,
  output reg  [7:0] cmd_wdata
);
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_offset = 8'h00;
    cmd_wdata = 8'h00;
  end
  // offset and data inverted once the strobe drops, so stale values never look valid
  task wr(input [7:0] o, input [7:0] d);
    begin
      @(posedge clk_sys);
      cmd_wr <= 1'b1;
      cmd_offset <= o;
      cmd_wdata <= d;
      @(posedge clk_sys);
      cmd_wr <= 1'b0;
      cmd_offset <= ~o;
      cmd_wdata <= ~d;
    end
  endtask
  task rd(input [7:0] o, output [7:0] d);
    begin
      @(posedge clk_sys);
      cmd_rd <= 1'b1;
      cmd_offset <= o;
      @(posedge clk_sys);
      cmd_rd <= 1'b0;
      cmd_offset <= ~o;
      @(posedge clk_sys);
      d = cmd_rvalid_ff ? cmd_rdata_ff : 8'hxx;
    end
  endtask
endmodule

// ===== src/strap_regmap.v
// strap sampling, gpio port muxing and vendor register map of the usb network controller
`timescale 1ns/100ps
`include "strap_regmap_consts.vh"
module strap_regmap #(
  parameter [15:0] MAKER_CODE    = 16'h1234,  // arbitrary value
  parameter [15:0] PART_CODE     = 16'h5678,  // arbitrary value
  parameter [7:0]  REVISION_CODE = 8'h0a,     // arbitrary value
  parameter [31:0] SW_RESET_CYC  = `SW_RESET_CYCLES
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        sys_rst,
  // strap and mode pins
  input  wire        phy_if_strap_hi,
  input  wire        phy_if_strap_lo,
  input  wire        eeprom_type_strap,
  input  wire        rx_header_format_strap,
  input  wire        clock_source_strap,
  input  wire        test_mode_one_pin,
  // decoded strap settings and software reset state
  output reg  [1:0]  phy_if_mode_ff,
  output reg         eeprom_force_small_ff,
  output reg         rx_header_four_ff,
  output reg         clk_from_crystal_ff,
  output reg         gpio_mode_ff,
  output reg         sw_reset_active_ff,
  // vendor register command port
  input  wire        cmd_wr,
  input  wire        cmd_rd,
  input  wire [7:0]  cmd_offset,
  input  wire [7:0]  cmd_wdata,
  output reg  [7:0]  cmd_rdata_ff,
  output reg         cmd_rvalid_ff,
  // station address load from eeprom
  input  wire        eeprom_load_valid,
  input  wire [2:0]  eeprom_load_index,
  input  wire [7:0]  eeprom_load_byte,
  // statistics events, one cycle pulses
  input  wire [5:0]  stat_event,
  // gpio ports 2 and 3
  input  wire [7:0]  port2_in,
  output reg  [7:0]  port2_out_ff,
  output reg  [7:0]  port2_oe_n_ff,
  input  wire [7:0]  port3_in,
  output reg  [7:0]  port3_out_ff,
  output reg  [7:0]  port3_oe_n_ff
);

  // ****************
  // pin synchronisers
  // ****************
  reg  [5:0]  strap_meta_ff;
  reg  [5:0]  strap_sync_ff;
  reg  [15:0] port_meta_ff;
  reg  [15:0] port_sync_ff;
  reg         rst_seen_ff;

  always @(posedge clk_sys) begin
    strap_meta_ff <= {test_mode_one_pin, clock_source_strap, rx_header_format_strap,
                      eeprom_type_strap, phy_if_strap_lo, phy_if_strap_hi};
    strap_sync_ff <= strap_meta_ff;
    port_meta_ff  <= {port3_in, port2_in};
    port_sync_ff  <= port_meta_ff;
  end

  // ****************
  // strap latch
  // ****************
  // straps settle during reset; capture on the first edge after release only
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rst_seen_ff           <= 1'b1;
      phy_if_mode_ff        <= `PHY_IF_MII;
      eeprom_force_small_ff <= 1'b0;
      rx_header_four_ff     <= 1'b0;
      clk_from_crystal_ff   <= 1'b0;
      gpio_mode_ff          <= 1'b0;
    end else if (rst_seen_ff) begin
      rst_seen_ff           <= 1'b0;
      phy_if_mode_ff        <= {strap_sync_ff[0], strap_sync_ff[1]};
      eeprom_force_small_ff <= strap_sync_ff[2];
      rx_header_four_ff     <= strap_sync_ff[3];
      clk_from_crystal_ff   <= strap_sync_ff[4];
      gpio_mode_ff          <= strap_sync_ff[5];
    end
  end

  // ****************
  // register storage
  // ****************
  reg  [7:0]  plain_ff [0:255];
  reg  [7:0]  station_ff [0:5];
  reg  [7:0]  count_ff [0:5];
  reg  [31:0] swr_cnt_ff;
  wire        soft_rst;
  wire        reg_rst;
  wire        clr_mode;
  wire        wr_hit_ctl;
  integer     i;

  assign soft_rst   = sw_reset_active_ff;
  assign reg_rst    = sys_rst | soft_rst;
  assign clr_mode   = plain_ff[`OFS_NET_CONTROL][`NCR_CLEAR_MODE_BIT];
  assign wr_hit_ctl = cmd_wr & (cmd_offset == `OFS_NET_CONTROL);

  // software reset: held for the settle time, or ended early by any control write with bit 0 clear
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      sw_reset_active_ff <= 1'b0;
      swr_cnt_ff         <= 32'h0000_0000;
    end else if (wr_hit_ctl & cmd_wdata[`NCR_SW_RESET_BIT]) begin
      sw_reset_active_ff <= 1'b1;
      swr_cnt_ff         <= SW_RESET_CYC;
    end else if (wr_hit_ctl | (swr_cnt_ff == 32'h0000_0001)) begin
      sw_reset_active_ff <= 1'b0;
      swr_cnt_ff         <= 32'h0000_0000;
    end else if (swr_cnt_ff != 32'h0000_0000) begin
      swr_cnt_ff <= swr_cnt_ff - 32'h0000_0001;
    end
  end

  function [7:0] rst_value;
    input [7:0] ofs;
    begin
      case (ofs)
        `OFS_BP_THRESH:    rst_value = `RST_BP_THRESH;
        `OFS_FLOW_THRESH:  rst_value = `RST_FLOW_THRESH;
        `OFS_EP_ADDRESS:   rst_value = `RST_EP_ADDRESS;
        `OFS_GP_CONTROL:   rst_value = `RST_GP_CONTROL;
        `OFS_EXT_PHY_ADDR: rst_value = `RST_EXT_PHY_ADDR;
        `OFS_PAUSE_CSR:    rst_value = `RST_PAUSE_CSR;
        `OFS_SQUELCH:      rst_value = `RST_SQUELCH;
        `OFS_TX_TALLY:     rst_value = `RST_TX_TALLY;
        `OFS_MCAST_LAST:   rst_value = `RST_MCAST_LAST;
        default:           rst_value = `RST_ZERO;
      endcase
    end
  endfunction

  function is_writable;
    input [7:0] ofs;
    begin
      case (ofs)
        `OFS_RX_STATUS, `OFS_RX_OVF_COUNT, `OFS_RX_TALLY, `OFS_TX_TALLY,
        `OFS_MAKER_LO, `OFS_MAKER_HI, `OFS_PART_LO, `OFS_PART_HI,
        `OFS_REVISION: is_writable = 1'b0;
        default:       is_writable = 1'b1;
      endcase
    end
  endfunction

  // general byte registers; station, counter and identity offsets are just unused slots
  always @(posedge clk_sys) begin
    if (reg_rst) begin
      for (i = 0; i < 256; i = i + 1) begin
        plain_ff[i] <= rst_value(i[7:0]);
      end
    end else if (cmd_wr & is_writable(cmd_offset)) begin
      plain_ff[cmd_offset] <= cmd_wdata;
    end
  end

  // station address: no reset value, only eeprom load or host write
  always @(posedge clk_sys) begin
    if (eeprom_load_valid && (eeprom_load_index < 3'd6)) begin
      station_ff[eeprom_load_index] <= eeprom_load_byte;
    end else if (cmd_wr && (cmd_offset >= `OFS_STATION_FIRST)
                 && (cmd_offset <= `OFS_STATION_LAST)) begin
      station_ff[cmd_offset[2:0] - 3'd0] <= cmd_wdata;
    end
  end

  // ****************
  // statistics counters
  // ****************
  // read clears unless clear-on-write mode is on (any write clears); a same-cycle event still counts
  wire [7:0] cnt_idx;
  assign cnt_idx = cmd_offset - `OFS_CNT_FIRST;

  always @(posedge clk_sys) begin
    for (i = 0; i < 6; i = i + 1) begin
      if (reg_rst) begin
        count_ff[i] <= 8'h00;
      end else if (((cmd_rd & ~clr_mode) | (cmd_wr & clr_mode))
                   && (cnt_idx == i[7:0]) && (cmd_offset >= `OFS_CNT_FIRST)) begin
        count_ff[i] <= stat_event[i] ? 8'h01 : 8'h00;
      end else if (stat_event[i]) begin
        count_ff[i] <= count_ff[i] + 8'h01;
      end
    end
  end

  // ****************
  // read path
  // ****************
  reg [7:0] nxt_rdata;

  always @* begin
    nxt_rdata = plain_ff[cmd_offset];
    if ((cmd_offset >= `OFS_STATION_FIRST) && (cmd_offset <= `OFS_STATION_LAST)) begin
      nxt_rdata = station_ff[cmd_offset[2:0]];
    end else if ((cmd_offset >= `OFS_CNT_FIRST) && (cmd_offset <= `OFS_CNT_LAST)) begin
      nxt_rdata = count_ff[cnt_idx[2:0]];
    end else begin
      case (cmd_offset)
        `OFS_MAKER_LO:   nxt_rdata = MAKER_CODE[7:0];
        `OFS_MAKER_HI:   nxt_rdata = MAKER_CODE[15:8];
        `OFS_PART_LO:    nxt_rdata = PART_CODE[7:0];
        `OFS_PART_HI:    nxt_rdata = PART_CODE[15:8];
        `OFS_REVISION:   nxt_rdata = REVISION_CODE;
        `OFS_PORT2_DATA: nxt_rdata = (plain_ff[`OFS_PORT2_DATA] & plain_ff[`OFS_PORT2_CONTROL])
                                     | (port_sync_ff[7:0] & ~plain_ff[`OFS_PORT2_CONTROL]);
        `OFS_PORT3_DATA: nxt_rdata = (plain_ff[`OFS_PORT3_DATA] & plain_ff[`OFS_PORT3_CONTROL])
                                     | (port_sync_ff[15:8] & ~plain_ff[`OFS_PORT3_CONTROL]);
        default:         nxt_rdata = plain_ff[cmd_offset];
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      cmd_rdata_ff  <= 8'h00;
      cmd_rvalid_ff <= 1'b0;
    end else begin
      cmd_rvalid_ff <= cmd_rd;
      if (cmd_rd) begin
        cmd_rdata_ff <= nxt_rdata;
      end
    end
  end

  // ****************
  // gpio pin drive
  // ****************
  // control bit 1 means output; pins float unless in gpio mode
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      port2_out_ff  <= 8'h00;
      port3_out_ff  <= 8'h00;
      port2_oe_n_ff <= 8'hff;
      port3_oe_n_ff <= 8'hff;
    end else begin
      port2_out_ff  <= plain_ff[`OFS_PORT2_DATA];
      port3_out_ff  <= plain_ff[`OFS_PORT3_DATA];
      port2_oe_n_ff <= ~(plain_ff[`OFS_PORT2_CONTROL] & {8{gpio_mode_ff}});
      port3_oe_n_ff <= ~(plain_ff[`OFS_PORT3_CONTROL] & {8{gpio_mode_ff}});
    end
  end

endmodule
